/* File: rtl/gesf_cfg.svh */
`ifndef GESF_CFG_SVH
`define GESF_CFG_SVH
// register offsets on the local register port
`define GESF_OFS_OUTBYTE   3'h1
`define GESF_OFS_STATUS    3'h3
`define GESF_OFS_MASK      3'h3
`define GESF_OFS_MODE      3'h4
`define GESF_OFS_AUXMR     3'h5
`define GESF_OFS_PASS      3'h5
// flag field inside status and mask bytes
`define GESF_FLAG_LSB      2
`define GESF_FLAG_MSB      6
// flag index inside the five-bit flag vector
`define GESF_IX_ERR        0
`define GESF_IX_CLR        1
`define GESF_IX_END        2
`define GESF_IX_TRG        3
`define GESF_IX_SEC        4
// address mode and aux config bits
`define GESF_ADM_HI        1
`define GESF_ADM_LO        0
`define GESF_EOS_EN_BIT    2
// aux mode register: selector in top bits, payload below
`define GESF_AUX_SEL_MSB   7
`define GESF_AUX_SEL_LSB   5
`define GESF_AUX_PAY_MSB   4
`define GESF_AUX_PAY_LSB   0
`define GESF_AUX_SEL_CMD   3'h0
`define GESF_AUX_SEL_RA    3'h4
`define GESF_AUX_VALID     5'h0f
`define GESF_AUX_NONVALID  5'h07
// reset values
`define GESF_RST_BYTE      8'h00
`define GESF_RST_FLAGS     5'h00
`define GESF_RST_AUX       5'h00
`endif

/* File: rtl/gesf_pkg.sv */
package gesf_pkg;
   // states and messages of the bus interface core, same clock
   typedef struct packed {
      logic tpas;
      logic lpas;
      logic scg;
      logic acds;
      logic dtas;
      logic lacs;
      logic eoi;
      logic dcas;
      logic sdys;
      logic sids;
      logic dac;
      logic rfd;
   } gesf_core_t;
   typedef logic [4:0] gesf_flags_t;
endpackage

/* File: rtl/gesf_top.sv */
`timescale 1ns/1ns
`include "gesf_cfg.svh"
module gesf_top
   import gesf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire gesf_core_t core,
   input  wire logic [2:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] din_byte,
   input  wire logic [7:0] eos_byte,
   input  wire logic [7:0] cmd_byte,
   output logic      [7:0] reg_rdata,
   output logic            dac_holdoff,
   output logic            irq
);

   // ==========================================================
   // decode
   // ==========================================================
   logic isr_rd;
   logic ptr_rd;
   logic mask_wr;
   logic mode_wr;
   logic auxcfg_wr;
   logic outbyte_wr;
   logic answer_wr;
   logic [2:0] aux_sel;
   logic [4:0] aux_pay;

   // register port strobes
   always_comb begin
      aux_sel    = reg_wdata[`GESF_AUX_SEL_MSB:`GESF_AUX_SEL_LSB];
      aux_pay    = reg_wdata[`GESF_AUX_PAY_MSB:`GESF_AUX_PAY_LSB];
      isr_rd     = reg_rd && (reg_addr == `GESF_OFS_STATUS);
      ptr_rd     = reg_rd && (reg_addr == `GESF_OFS_PASS);
      mask_wr    = reg_wr && (reg_addr == `GESF_OFS_MASK);
      mode_wr    = reg_wr && (reg_addr == `GESF_OFS_MODE);
      outbyte_wr = reg_wr && (reg_addr == `GESF_OFS_OUTBYTE);
      auxcfg_wr  = reg_wr && (reg_addr == `GESF_OFS_AUXMR)
                   && (aux_sel == `GESF_AUX_SEL_RA);
      answer_wr = reg_wr && (reg_addr == `GESF_OFS_AUXMR)
                  && (aux_sel == `GESF_AUX_SEL_CMD)
                  && ((aux_pay == `GESF_AUX_VALID)
                      || (aux_pay == `GESF_AUX_NONVALID));
   end

   // ==========================================================
   // configuration registers
   // ==========================================================
   logic [7:0]  mode_r;
   logic [7:0]  mode_nxt;
   logic [4:0]  auxcfg_r;
   logic [4:0]  auxcfg_nxt;
   gesf_flags_t mask_r;
   gesf_flags_t mask_nxt;

   // write-only config loads
   always_comb begin
      mode_nxt   = mode_wr   ? reg_wdata : mode_r;
      auxcfg_nxt = auxcfg_wr ? aux_pay   : auxcfg_r;
      mask_nxt   = mask_wr   ?
                   reg_wdata[`GESF_FLAG_MSB:`GESF_FLAG_LSB] : mask_r;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r   <= `GESF_RST_BYTE;
         auxcfg_r <= `GESF_RST_AUX;
         mask_r   <= `GESF_RST_FLAGS;
      end else begin
         mode_r   <= mode_nxt;
         auxcfg_r <= auxcfg_nxt;
         mask_r   <= mask_nxt;
      end
   end

   // ==========================================================
   // event detection
   // ==========================================================
   logic        eos_match;
   gesf_flags_t ev;
   gesf_flags_t ev_prev_r;
   gesf_flags_t rise;
   logic        sdys_prev_r;

   // raw set conditions, one per flag
   always_comb begin
      eos_match = (din_byte == eos_byte);
      ev = `GESF_RST_FLAGS;
      ev[`GESF_IX_SEC] = mode_r[`GESF_ADM_HI] && mode_r[`GESF_ADM_LO]
                         && (core.tpas || core.lpas)
                         && core.scg && core.acds;
      ev[`GESF_IX_TRG] = core.dtas;
      ev[`GESF_IX_END] = core.lacs && core.acds
                         && (core.eoi || (eos_match
                         && auxcfg_r[`GESF_EOS_EN_BIT]));
      ev[`GESF_IX_CLR] = core.dcas;
      // lost outgoing byte
      ev[`GESF_IX_ERR] = (core.sdys && core.dac && core.rfd)
                         || (core.sids && outbyte_wr)
                         || (sdys_prev_r && core.sids);
      rise = ev & ~ev_prev_r; // entry into each condition
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ev_prev_r   <= `GESF_RST_FLAGS;
         sdys_prev_r <= 1'b0;
      end else begin
         ev_prev_r   <= ev;
         sdys_prev_r <= core.sdys;
      end
   end

   // ==========================================================
   // status flags and handshake hold
   // ==========================================================
   gesf_flags_t flag_r;
   gesf_flags_t flag_nxt;
   gesf_flags_t pend_r;
   gesf_flags_t pend_nxt;
   logic [7:0]  ptr_r;
   logic [7:0]  ptr_nxt;
   logic        hold_r;
   logic        hold_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;

   // sticky flags, clear on read, deferred set during read
   always_comb begin
      if (isr_rd) begin
         flag_nxt = `GESF_RST_FLAGS;
         // earlier deferred events survive back-to-back reads
         pend_nxt = pend_r | rise;
      end else begin
         flag_nxt = flag_r | pend_r | rise;
         pend_nxt = `GESF_RST_FLAGS;
      end
      ptr_nxt  = rise[`GESF_IX_SEC] ? cmd_byte : ptr_r;
      // set beats the answering command
      if (rise[`GESF_IX_SEC]) begin
         hold_nxt = 1'b1;
      end else if (answer_wr) begin
         hold_nxt = 1'b0;
      end else begin
         hold_nxt = hold_r;
      end
      irq_nxt = |(flag_nxt & mask_nxt);
      rdata_nxt = `GESF_RST_BYTE;
      if (isr_rd) begin
         rdata_nxt[`GESF_FLAG_MSB:`GESF_FLAG_LSB] = flag_r;
      end else if (ptr_rd) begin
         rdata_nxt = ptr_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_r  <= `GESF_RST_FLAGS;
         pend_r  <= `GESF_RST_FLAGS;
         ptr_r   <= `GESF_RST_BYTE;
         hold_r  <= 1'b0;
         irq_r   <= 1'b0;
         rdata_r <= `GESF_RST_BYTE;
      end else begin
         flag_r  <= flag_nxt;
         pend_r  <= pend_nxt;
         ptr_r   <= ptr_nxt;
         hold_r  <= hold_nxt;
         irq_r   <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata   = rdata_r;
   assign dac_holdoff = hold_r;
   assign irq         = irq_r;

   // ==========================================================
   // assertions
   // ==========================================================
   addr_sets_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      rise[`GESF_IX_SEC] && !isr_rd |=> flag_r[`GESF_IX_SEC])
      else $error("address flag not set");
   mode_gates_addr_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !mode_r[`GESF_ADM_HI] || !mode_r[`GESF_ADM_LO]
      |-> !ev[`GESF_IX_SEC])
      else $error("address flag outside mode three");
   ptr_capture_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      rise[`GESF_IX_SEC] |=> ptr_r == $past(cmd_byte))
      else $error("secondary byte not captured");
   hold_until_ans_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      hold_r && !answer_wr |=> hold_r)
      else $error("handshake hold released early");
   hold_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      answer_wr && !rise[`GESF_IX_SEC] |=> !hold_r)
      else $error("handshake hold not released");
   trig_sets_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(core.dtas) && !isr_rd |=> flag_r[`GESF_IX_TRG])
      else $error("trigger flag not set");
   end_eos_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !core.eoi && !auxcfg_r[`GESF_EOS_EN_BIT]
      |-> !ev[`GESF_IX_END])
      else $error("end flag without terminator");
   clr_sets_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(core.dcas) && !isr_rd |=> flag_r[`GESF_IX_CLR])
      else $error("device clear flag not set");
   fault_on_write_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      core.sids && outbyte_wr && !ev_prev_r[`GESF_IX_ERR] && !isr_rd
      |=> flag_r[`GESF_IX_ERR])
      else $error("fault flag not set on write");
   read_clears_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      isr_rd |=> flag_r == `GESF_RST_FLAGS)
      else $error("status read did not clear");
   pend_lands_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      isr_rd ##1 !isr_rd
      |=> (flag_r & $past(pend_r)) == $past(pend_r))
      else $error("deferred events not set");
   read_defer_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      isr_rd && rise[`GESF_IX_TRG] ##1 !isr_rd
      |=> flag_r[`GESF_IX_TRG])
      else $error("event during read lost");
   sticky_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      flag_r[`GESF_IX_CLR] && !isr_rd |=> flag_r[`GESF_IX_CLR])
      else $error("flag dropped without read");
   irq_mask_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq_r == |(flag_r & mask_r))
      else $error("interrupt does not match mask");
endmodule

/* File: verif/gesf_gpib_peer.sv */
`timescale 1ns/1ns
// ==========================================
// bus peer: talker, listener, device and handshake states
module gesf_gpib_peer
   import gesf_pkg::*;
(
   input  wire logic       clk,
   output gesf_core_t      core,
   output logic      [7:0] cmd_byte,
   output logic      [7:0] din_byte
);
   // idle: no state active
   initial begin
      core     = '0;
      cmd_byte = 8'h00;
      din_byte = 8'h00;
   end
   // two cycles of states, then release with inverted bytes
   task automatic pulse(input gesf_core_t a, input gesf_core_t b,
                        input logic [7:0] cb, input logic [7:0] db);
      @(posedge clk);
      #5;
      core     = a;
      cmd_byte = cb;
      din_byte = db;
      @(posedge clk);
      #5;
      core = b;
      @(posedge clk);
      #5;
      core     = '0;
      cmd_byte = ~cb;
      din_byte = ~db;
   endtask
endmodule

/* File: verif/gpib_event_status_flags_test.sv */
`timescale 1ns/1ns
// ==========================================
// bench for the event status flags
module gpib_event_status_flags_test;
   import gesf_pkg::*;
   logic        clk       = 1'b0;
   logic        rst_n     = 1'b0;
   logic  [2:0] reg_addr  = 3'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic  [7:0] reg_wdata = 8'h00;
   logic  [7:0] eos_byte  = 8'h0a;
   logic  [7:0] cmd_byte, din_byte, reg_rdata, rd_val, cb;
   logic        dac_holdoff, irq;
   gesf_core_t  core;
   int          n_errors  = 0;
   int          tests_run = 0;
   // aux, first state, second state, data-in, expected status
   logic [47:0] tab [10] = '{48'h80_080_080_00_20, 48'h80_160_160_00_10,
      48'h80_140_140_0a_00, 48'h84_140_140_0a_10, 48'h84_140_140_0b_00,
      48'h80_010_010_00_08, 48'h80_00b_00b_00_04, 48'h80_008_004_00_04,
      48'h80_004_004_00_00, 48'h80_003_003_00_00};
   // clock
   always #25 clk = ~clk;
   gesf_top uut (.clk(clk), .rst_n(rst_n), .core(core),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .din_byte(din_byte), .eos_byte(eos_byte),
      .cmd_byte(cmd_byte), .reg_rdata(reg_rdata),
      .dac_holdoff(dac_holdoff), .irq(irq));
   gesf_gpib_peer peer (.clk(clk), .core(core), .cmd_byte(cmd_byte),
      .din_byte(din_byte));
   // ==========================================
   // access tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #5;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clk);
      #5;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      #5;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk);
      #5;
      reg_rd = 1'b0;
      d      = reg_rdata;
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // watchdog
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      test_done();
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #5;
      rst_n = 1'b1;
      rd(3'h3, rd_val);
      chk(rd_val, 8'h00);
      wr(3'h3, 8'h7c);
      // one event at a time, sticky across idle cycles
      foreach (tab[i]) begin
         wr(3'h5, tab[i][47:40]);
         peer.pulse(tab[i][39:28], tab[i][27:16], 8'h00, tab[i][15:8]);
         repeat (3) @(posedge clk);
         #5;
         chk({7'h00, irq}, {7'h00, |tab[i][7:0]});
         rd(3'h3, rd_val);
         chk(rd_val, tab[i][7:0]);
         rd(3'h3, rd_val);
         chk(rd_val, 8'h00);
      end
      // outgoing byte written during source idle
      fork
         peer.pulse(12'h004, 12'h004, 8'h00, 8'h00);
         begin
            @(posedge clk);
            wr(3'h1, 8'h55);
         end
      join
      rd(3'h3, rd_val);
      chk(rd_val, 8'h04);
      // event in the same cycle as a status read
      fork
         peer.pulse(12'h080, 12'h080, 8'h00, 8'h00);
         rd(3'h3, rd_val);
      join
      chk(rd_val, 8'h00);
      rd(3'h3, rd_val);
      chk(rd_val, 8'h20);
      // masked: no interrupt, flag still set
      wr(3'h3, 8'h00);
      peer.pulse(12'h080, 12'h080, 8'h00, 8'h00);
      chk({7'h00, irq}, 8'h00);
      rd(3'h3, rd_val);
      chk(rd_val, 8'h20);
      // secondary address in mode three, answered valid then non-valid
      wr(3'h3, 8'h40);
      wr(3'h4, 8'h03);
      for (int k = 0; k < 2; k++) begin
         cb = k ? 8'ha3 : 8'h65;
         peer.pulse(k ? 12'h700 : 12'hb00, k ? 12'h700 : 12'hb00, cb, 8'h00);
         chk({7'h00, dac_holdoff}, 8'h01);
         chk({7'h00, irq}, 8'h01);
         rd(3'h5, rd_val);
         chk(rd_val, cb);
         chk({7'h00, dac_holdoff}, 8'h01);
         wr(3'h5, k ? 8'h07 : 8'h0f);
         chk({7'h00, dac_holdoff}, 8'h00);
         rd(3'h3, rd_val);
         chk(rd_val, 8'h40);
      end
      // address modes one and two leave the flag alone
      for (int j = 1; j < 3; j++) begin
         wr(3'h4, 8'(j));
         peer.pulse(12'hb00, 12'hb00, 8'h65, 8'h00);
         chk({7'h00, dac_holdoff}, 8'h00);
         rd(3'h3, rd_val);
         chk(rd_val, 8'h00);
      end
      test_done();
   end
endmodule
